// ---- verilog/pie_pkg.sv ----
// Package: register map, field positions and sizes of the PWM interrupt-enable block
package pie_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SM = 4;
  localparam int NUM_CAP = 6;
  localparam int NUM_CMP = 6;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] SM_STRIDE = 10'h030;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h012;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h013;
  localparam logic [IDX_W-1:0] IDX_DMA_EN = 10'h014;
  localparam logic [IDX_W-1:0] IDX_SUM_STS = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_SUM_MASK = 10'h0c1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_RELOAD_ERR = 13;
  localparam int BIT_RELOAD = 12;
  localparam int CAP_LSB = 6;
  localparam int CMP_LSB = 0;
  localparam int BIT_VAL_DMA = 9;
  localparam int CAP_DMA_LSB = 0;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] IRQ_EN_WMASK = 16'h3fff;
  localparam logic [REG_W-1:0] DMA_EN_WMASK = 16'h03ff;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/pie_reg_if.sv ----
// Interface: register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface pie_reg_if;
  import pie_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface

// ---- verilog/pie_axil_slave.sv ----
// Module: AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
module pie_axil_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write address and data
  input wire logic [pie_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // Write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // Read
  input wire logic [pie_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register side
  pie_reg_if.bus rif
);
  import pie_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pie_axi_s;

  pie_axi_s st_r;
  pie_axi_s st_nxt;

  // ----------------------------------------------------------------
  // Channel logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // No new address or data while a response waits, so one write at a time
    o_awready = !st_r.aw_got && !st_r.bvalid;
    o_wready = !st_r.w_got && !st_r.bvalid;
    o_arready = !st_r.rvalid;
    rif.wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    rif.wr_addr = st_r.waddr;
    rif.wr_data = st_r.wdata;
    rif.wr_strb = st_r.wstrb;
    rif.rd_en = i_arvalid && !st_r.rvalid;
    rif.rd_addr = i_araddr;
    if (i_awvalid && o_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    if (rif.wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (rif.rd_en) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rif.rd_data;
      st_nxt.rresp = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_bresp = st_r.bresp;
  assign o_bvalid = st_r.bvalid;
  assign o_rdata = st_r.rdata;
  assign o_rresp = st_r.rresp;
  assign o_rvalid = st_r.rvalid;
endmodule

// ---- verilog/pie_sm_flags.sv ----
// Module: status flags of one PWM submodule with set, write-one-clear and DMA-done clear
`timescale 1ns/1ps
module pie_sm_flags (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Events
  input wire logic i_reload,
  input wire logic i_load_ok,
  input wire logic i_unsynced,
  input wire logic [pie_pkg::NUM_CAP-1:0] i_capture,
  input wire logic [pie_pkg::NUM_CMP-1:0] i_compare,
  // Clears
  input wire logic [pie_pkg::REG_W-1:0] i_w1c,
  input wire logic [pie_pkg::REG_W-1:0] i_dma_en,
  input wire logic [pie_pkg::NUM_CAP-1:0] i_cap_dma_done,
  input wire logic i_val_dma_done,
  // Flags
  output logic [pie_pkg::REG_W-1:0] o_flags
);
  import pie_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] flags;
  } pie_flags_s;

  pie_flags_s st_r;
  pie_flags_s st_nxt;
  logic [REG_W-1:0] set_v;
  logic [REG_W-1:0] clr_v;
  logic val_dma;

  always_comb begin
    st_nxt = st_r;
    set_v = '0;
    clr_v = '0;
    val_dma = i_dma_en[BIT_VAL_DMA];
    set_v[BIT_RELOAD] = i_reload; // RQ13
    set_v[BIT_RELOAD_ERR] = i_reload && !i_load_ok && i_unsynced; // RQ14
    set_v[CAP_LSB +: NUM_CAP] = i_capture; // RQ15
    set_v[CMP_LSB +: NUM_CMP] = i_compare; // RQ16
    clr_v[BIT_RELOAD_ERR] = i_w1c[BIT_RELOAD_ERR];
    clr_v[BIT_RELOAD] = val_dma ? i_val_dma_done : i_w1c[BIT_RELOAD];
    // Clear source follows the circuit's DMA mode
    for (int k = 0; k < NUM_CAP; k++) begin
      clr_v[CAP_LSB+k] = i_dma_en[CAP_DMA_LSB+k] ? i_cap_dma_done[k] : i_w1c[CAP_LSB+k]; // RQ15
    end
    clr_v[CMP_LSB +: NUM_CMP] = i_w1c[CMP_LSB +: NUM_CMP]; // RQ16
    // A flag set in the clearing cycle survives
    st_nxt.flags = ((st_r.flags & ~clr_v) | set_v) & IRQ_EN_WMASK;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_flags = st_r.flags;
endmodule

// ---- verilog/pie_top.sv ----
// Module: PWM submodule interrupt-enable registers, request gating and bus access
//
// Operation
// RQ1 - Enable register bits 15 and 14 read zero and ignore writes.
// RQ2 - One enable register per submodule, index 13h, four submodules, 48-word stride.
// RQ3 - Reload-error enable bit 13 gates the reload error flag; reset clears.
// RQ4 - Reload enable bit 12 gates the reload flag; reset clears.
// RQ5 - Enable bit 11 gates the capture A1 flag onto the request.
// RQ6 - Enable bit 10 gates the capture A0 flag onto the request.
// RQ7 - Enable bit 9 gates the capture B1 flag onto the request.
// RQ8 - Enable bit 8 gates the capture B0 flag onto the request.
// RQ9 - Enable bit 7 gates the capture X1 flag onto the request.
// RQ10 - Enable bit 6 gates the capture X0 flag onto the request.
// RQ11 - Software never sets a capture interrupt enable with its DMA enable.
// RQ12 - Each compare enable bit gates its compare flag onto the compare request.
// RQ13 - Reload flag sets on every reload, regardless of buffer load ok.
// RQ14 - Reload error sets on reload without load ok while buffers are unsynced.
// RQ15 - Capture flag sets on capture; cleared by write-one or DMA done.
// RQ16 - Compare flag sets on counter match; write-one clears it.
// RQ17 - Compare enables at bits 5 to 0; every enable resets to zero.
// RQ18 - Each request is the level AND of flag and enable.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module pie_top (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // AXI4-Lite write
  input wire logic [pie_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [pie_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Submodule events, one bit or group per submodule
  input wire logic [pie_pkg::NUM_SM-1:0] I_RELOAD,
  input wire logic [pie_pkg::NUM_SM-1:0] I_BUFFER_LOAD_OK,
  input wire logic [pie_pkg::NUM_SM-1:0] I_BUFFERS_UNSYNCED,
  input wire logic [pie_pkg::NUM_SM*pie_pkg::NUM_CAP-1:0] I_CAPTURE,
  input wire logic [pie_pkg::NUM_SM*pie_pkg::NUM_CMP-1:0] I_COMPARE_MATCH,
  input wire logic [pie_pkg::NUM_SM*pie_pkg::NUM_CAP-1:0] I_CAP_DMA_DONE,
  input wire logic [pie_pkg::NUM_SM-1:0] I_VAL_DMA_DONE,
  // CPU requests
  output logic [pie_pkg::NUM_SM-1:0] O_RELOAD_IRQ,
  output logic [pie_pkg::NUM_SM-1:0] O_RELOAD_ERR_IRQ,
  output logic [pie_pkg::NUM_SM-1:0] O_CAPTURE_IRQ,
  output logic [pie_pkg::NUM_SM-1:0] O_COMPARE_IRQ,
  output logic O_IRQ,
  // DMA enables for the DMA request logic
  output logic [pie_pkg::NUM_SM*pie_pkg::NUM_CAP-1:0] O_CAP_DMA_REQ_EN,
  output logic [pie_pkg::NUM_SM-1:0] O_VAL_DMA_REQ_EN
);
  import pie_pkg::*;

  typedef struct packed {
    logic [NUM_SM-1:0][REG_W-1:0] irq_enable_reg;
    logic [NUM_SM-1:0][REG_W-1:0] dma_request_enables;
    logic [NUM_SM-1:0] sum_sts;
    logic [NUM_SM-1:0] sum_mask;
  } pie_regs_s;

  pie_regs_s st_r;
  pie_regs_s st_nxt;
  pie_reg_if rif ();
  logic [NUM_SM-1:0][REG_W-1:0] status_flags_reg;
  logic [NUM_SM-1:0][REG_W-1:0] sts_w1c;
  logic [NUM_SM-1:0] sm_req;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  pie_axil_slave u_axil (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_awaddr(I_AWADDR),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .o_bresp(O_BRESP),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .i_araddr(I_ARADDR),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .rif(rif)
  );

  // ----------------------------------------------------------------
  // Per-submodule flags and request gating
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_SM; g++) begin : g_sm
    logic [REG_W-1:0] req;
    pie_sm_flags u_flags (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_reload(I_RELOAD[g]),
      .i_load_ok(I_BUFFER_LOAD_OK[g]),
      .i_unsynced(I_BUFFERS_UNSYNCED[g]),
      .i_capture(I_CAPTURE[g*NUM_CAP +: NUM_CAP]),
      .i_compare(I_COMPARE_MATCH[g*NUM_CMP +: NUM_CMP]),
      .i_w1c(sts_w1c[g]),
      .i_dma_en(st_r.dma_request_enables[g]),
      .i_cap_dma_done(I_CAP_DMA_DONE[g*NUM_CAP +: NUM_CAP]),
      .i_val_dma_done(I_VAL_DMA_DONE[g]),
      .o_flags(status_flags_reg[g])
    );
    // Requests are levels that follow flag and enable without delay
    assign req = status_flags_reg[g] & st_r.irq_enable_reg[g]; // RQ18
    assign O_RELOAD_ERR_IRQ[g] = req[BIT_RELOAD_ERR]; // RQ3
    assign O_RELOAD_IRQ[g] = req[BIT_RELOAD]; // RQ4
    // Bits 11..6 gate A1, A0, B1, B0, X1, X0 in that order
    assign O_CAPTURE_IRQ[g] = |req[CAP_LSB +: NUM_CAP]; // RQ5 RQ6 RQ7 RQ8 RQ9 RQ10
    assign O_COMPARE_IRQ[g] = |req[CMP_LSB +: NUM_CMP]; // RQ12 RQ17
    assign sm_req[g] = |req;
    assign O_CAP_DMA_REQ_EN[g*NUM_CAP +: NUM_CAP] =
      st_r.dma_request_enables[g][CAP_DMA_LSB +: NUM_CAP];
    assign O_VAL_DMA_REQ_EN[g] = st_r.dma_request_enables[g][BIT_VAL_DMA];
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic [IDX_W-1:0] base;
    logic [REG_W-1:0] lanes;
    logic [REG_W-1:0] wval;
    logic sum_rd;
    widx = rif.wr_addr[ADDR_W-1:2];
    ridx = rif.rd_addr[ADDR_W-1:2];
    base = '0;
    lanes = {{8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
    wval = rif.wr_data[REG_W-1:0];
    sum_rd = 1'b0;
    st_nxt = st_r;
    sts_w1c = '0;
    rif.wr_ok = 1'b0;
    rif.rd_ok = 1'b0;
    rif.rd_data = '0;
    for (int i = 0; i < NUM_SM; i++) begin
      base = IDX_W'(i * SM_STRIDE); // RQ2
      if (rif.wr_en) begin
        if (widx == base + IDX_STATUS) begin
          rif.wr_ok = 1'b1;
          sts_w1c[i] = wval & lanes;
        end else if (widx == base + IDX_IRQ_EN) begin
          rif.wr_ok = 1'b1;
          st_nxt.irq_enable_reg[i] = ((st_r.irq_enable_reg[i] & ~lanes) | (wval & lanes))
            & IRQ_EN_WMASK; // RQ1
        end else if (widx == base + IDX_DMA_EN) begin
          rif.wr_ok = 1'b1;
          st_nxt.dma_request_enables[i] =
            ((st_r.dma_request_enables[i] & ~lanes) | (wval & lanes)) & DMA_EN_WMASK;
        end
      end
      if (rif.rd_en) begin
        if (ridx == base + IDX_STATUS) begin
          rif.rd_ok = 1'b1;
          rif.rd_data = {16'h0000, status_flags_reg[i]};
        end else if (ridx == base + IDX_IRQ_EN) begin
          rif.rd_ok = 1'b1;
          rif.rd_data = {16'h0000, st_r.irq_enable_reg[i]}; // RQ1
        end else if (ridx == base + IDX_DMA_EN) begin
          rif.rd_ok = 1'b1;
          rif.rd_data = {16'h0000, st_r.dma_request_enables[i]};
        end
      end
    end
    if (rif.wr_en && widx == IDX_SUM_MASK) begin
      rif.wr_ok = 1'b1;
      if (rif.wr_strb[0]) begin
        st_nxt.sum_mask = rif.wr_data[NUM_SM-1:0];
      end
    end else if (rif.wr_en && widx == IDX_SUM_STS) begin
      // Read-only; the write is acknowledged and has no effect
      rif.wr_ok = 1'b1;
    end
    if (rif.rd_en && ridx == IDX_SUM_STS) begin
      rif.rd_ok = 1'b1;
      rif.rd_data = {28'h0000000, st_r.sum_sts};
      sum_rd = 1'b1;
    end else if (rif.rd_en && ridx == IDX_SUM_MASK) begin
      rif.rd_ok = 1'b1;
      rif.rd_data = {28'h0000000, st_r.sum_mask};
    end
    // Read clears, but a request still standing sets the bit again at once
    st_nxt.sum_sts = (sum_rd ? '0 : st_r.sum_sts) | sm_req;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      st_r <= '0; // RQ3 RQ4 RQ17
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_IRQ = |(st_r.sum_sts & st_r.sum_mask);
endmodule

// ---- tb/pie_top_props.sv ----
// Checker: port-level assertions of the interrupt-enable block
`timescale 1ns/1ps
module pie_props (
  // Clock and reset
  input logic I_SYS_CLK,
  input logic I_RST,
  // Bus
  input logic O_AWREADY,
  input logic O_WREADY,
  input logic [1:0] O_BRESP,
  input logic O_BVALID,
  input logic I_BREADY,
  input logic I_ARVALID,
  input logic O_ARREADY,
  input logic [31:0] O_RDATA,
  input logic O_RVALID,
  input logic I_RREADY,
  // Events and requests
  input logic [pie_pkg::NUM_SM-1:0] I_RELOAD,
  input logic [pie_pkg::NUM_SM-1:0] I_BUFFER_LOAD_OK,
  input logic [pie_pkg::NUM_SM-1:0] I_BUFFERS_UNSYNCED,
  input logic [pie_pkg::NUM_SM-1:0] O_RELOAD_IRQ,
  input logic [pie_pkg::NUM_SM-1:0] O_RELOAD_ERR_IRQ
);
  import pie_pkg::*;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence ar_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  sequence err_event;
    $past(I_RELOAD[0]) && !$past(I_BUFFER_LOAD_OK[0]) && $past(I_BUFFERS_UNSYNCED[0]);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_rd_answer: assert property (ar_taken |=> O_RVALID) else $error("read not answered");
  a_rd_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  a_wr_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response not held");
  a_ar_block: assert property (O_RVALID |-> !O_ARREADY) else $error("read overlap");
  a_wr_block: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write overlap");
  a_rd_upper: assert property (O_RVALID |-> O_RDATA[31:14] == 18'h0)
    else $error("reserved read bits set");
  a_reload_cause: assert property ($rose(O_RELOAD_IRQ[0]) |->
    $past(I_RELOAD[0]) || $rose(O_BVALID)) else $error("reload request without cause");
  a_err_cause: assert property ($rose(O_RELOAD_ERR_IRQ[0]) |-> err_event or $rose(O_BVALID))
    else $error("reload error request without cause");
  a_err_drop: assert property ($fell(O_RELOAD_ERR_IRQ[0]) |-> $rose(O_BVALID) || $past(I_RST))
    else $error("reload error request dropped alone");
endmodule

bind pie_top pie_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .I_RELOAD(I_RELOAD),
  .I_BUFFER_LOAD_OK(I_BUFFER_LOAD_OK), .I_BUFFERS_UNSYNCED(I_BUFFERS_UNSYNCED),
  .O_RELOAD_IRQ(O_RELOAD_IRQ), .O_RELOAD_ERR_IRQ(O_RELOAD_ERR_IRQ));

// ---- tb/pie_cpu_model.sv ----
// Partner: CPU interrupt controller sensing request levels
`timescale 1ns/1ps
module pie_cpu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests
  input wire logic [15:0] i_req,
  input wire logic i_irq,
  // Observation
  output logic [15:0] o_pend,
  output logic o_seen
);
  // Request lines are level sensed, one that drops before service is lost; the summary irq is latched in o_seen
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pend <= '0;
      o_seen <= 1'b0;
    end else begin
      o_pend <= i_req;
      o_seen <= o_seen | i_irq;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Testbench: bus, event and request checks of the interrupt-enable block
`timescale 1ns/1ps
module tb_top;
  import pie_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, got;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wrd, bv, arr, rv, irq, seen;
  logic [1:0] br, rr, gresp;
  logic [3:0] rel = '0, lok = '0, o_rel, o_err, o_cap, o_cmp, vde;
  logic [3:0] uns = 4'hf, vdd = '0;
  logic [23:0] cap = '0, cmp = '0, cde, cdd = '0;
  logic [15:0] e, f, pend;
  logic [15:0] v [NUM_SM];
  int errors = 0, n_checks = 0, cyc = 0;

  always #10 clk = ~clk;

  pie_top dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'h3), .I_WVALID(wv), .O_WREADY(wrd),
    .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bre), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rre),
    .I_RELOAD(rel), .I_BUFFER_LOAD_OK(lok), .I_BUFFERS_UNSYNCED(uns), .I_CAPTURE(cap),
    .I_COMPARE_MATCH(cmp), .I_CAP_DMA_DONE(cdd), .I_VAL_DMA_DONE(vdd),
    .O_RELOAD_IRQ(o_rel), .O_RELOAD_ERR_IRQ(o_err), .O_CAPTURE_IRQ(o_cap),
    .O_COMPARE_IRQ(o_cmp), .O_IRQ(irq), .O_CAP_DMA_REQ_EN(cde), .O_VAL_DMA_REQ_EN(vde));

  pie_cpu_model cpu_u (.i_clk(clk), .i_rst(rst), .i_req({o_err, o_rel, o_cap, o_cmp}),
    .i_irq(irq), .o_pend(pend), .o_seen(seen));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] ad(input int s, input logic [IDX_W-1:0] x);
    ad = ADDR_W'((SM_STRIDE * s + x) * 4);
  endfunction

  // Request of one submodule from flags and enables
  function automatic logic [3:0] ex(input logic [15:0] fl, input logic [15:0] en);
    logic [15:0] g;
    g = fl & en;
    ex = {g[13], g[12], |g[11:6], |g[5:0]};
  endfunction

  function automatic logic [3:0] rq(input int s);
    rq = {o_err[s], o_rel[s], o_cap[s], o_cmp[s]};
  endfunction

  // Place one submodule's requests in the partner's pending word
  function automatic logic [15:0] pk(input int s, input logic [3:0] r);
    pk = '0;
    for (int k = 0; k < 4; k++) pk[4*k+s] = r[k];
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input int s, input logic [IDX_W-1:0] x, input logic [15:0] d);
    @(posedge clk);
    awa <= ad(s, x);
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    gresp = br;
    @(negedge clk);
  endtask

  task automatic rdreg(input int s, input logic [IDX_W-1:0] x);
    @(posedge clk);
    ara <= ad(s, x);
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    got = rd;
    gresp = rr;
    @(negedge clk);
  endtask

  // Buffers unsynced comes from uns, high except in the coherent-buffer check; load ok only for the plain reload case
  task automatic ev(input int s, input int b);
    @(posedge clk);
    rel[s] <= (b >= 12);
    lok[s] <= (b == 12);
    if (b >= 6 && b < 12) cap[6*s+b-6] <= 1'b1;
    if (b < 6) cmp[6*s+b] <= 1'b1;
    @(posedge clk);
    rel <= '0;
    cap <= '0;
    cmp <= '0;
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(61));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    for (int s = 0; s < NUM_SM; s++) begin
      rdreg(s, IDX_IRQ_EN);
      chk("en_reset", got, 32'(REG_RESET));
      v[s] = 16'($urandom);
      wr(s, IDX_IRQ_EN, v[s] | 16'hc000);
      chk("en_bresp", 32'(gresp), 32'(RESP_OKAY));
    end
    for (int s = 0; s < NUM_SM; s++) begin
      rdreg(s, IDX_IRQ_EN);
      chk("en_rw", got, 32'(v[s] & IRQ_EN_WMASK));
      rdreg(s, IDX_DMA_EN);
      chk("dma_apart", got, 32'h0);
    end
    rdreg(0, 10'h3ff);
    chk("unmapped_resp", 32'(gresp), 32'(RESP_SLVERR));
    chk("unmapped_data", got, 32'h0);
    wr(0, 10'h3ff, 16'hffff);
    chk("unmapped_wr", 32'(gresp), 32'(RESP_SLVERR));
    // DMA enables stay clear, so capture enables never meet them
    for (int s = 0; s < NUM_SM; s++) begin
      for (int b = 0; b < 14; b++) begin
        e = 16'($urandom) & IRQ_EN_WMASK & ~(16'h1 << b);
        f = (b == 13) ? 16'h3000 : 16'h1 << b;
        wr(s, IDX_IRQ_EN, e);
        ev(s, b);
        chk("req_off", 32'(rq(s)), 32'(ex(f, e)));
        wr(s, IDX_IRQ_EN, e | f);
        chk("req_on", 32'(rq(s)), 32'(ex(f, e | f)));
        chk("cpu_pend", 32'(pend), 32'(pk(s, ex(f, e | f))));
        wr(s, IDX_STATUS, f);
        chk("req_clear", 32'(rq(s)), 32'h0);
      end
    end
    // Coherent buffers: a reload without load ok raises no error
    @(posedge clk);
    uns <= 4'h0;
    ev(0, 13);
    rdreg(0, IDX_STATUS);
    chk("err_coherent", got, 32'h00001000);
    wr(0, IDX_STATUS, 16'hffff);
    @(posedge clk);
    uns <= 4'hf;
    // DMA mode: write-one is refused and only the done pulse clears
    wr(1, IDX_IRQ_EN, 16'h0000);
    wr(1, IDX_DMA_EN, 16'h0220);
    chk("dma_out", 32'({cde, vde}), 32'({24'h000800, 4'h2}));
    ev(1, 11);
    ev(1, 12);
    wr(1, IDX_STATUS, 16'h1800);
    rdreg(1, IDX_STATUS);
    chk("dma_w1c", got, 32'h00001800);
    @(posedge clk);
    cdd[11] <= 1'b1;
    vdd[1] <= 1'b1;
    @(posedge clk);
    cdd <= '0;
    vdd <= '0;
    @(negedge clk);
    rdreg(1, IDX_STATUS);
    chk("dma_done", got, 32'h0);
    wr(1, IDX_DMA_EN, 16'h0000);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(0, IDX_SUM_MASK, 16'h000f);
    chk("irq_unmasked", 32'(irq), 32'h1);
    rdreg(0, IDX_SUM_STS);
    chk("summary", got, 32'h0000000f);
    repeat (2) @(negedge clk);
    chk("irq_cleared", 32'(irq), 32'h0);
    chk("cpu_seen", 32'(seen), 32'h1);
    complete_run();
  end
endmodule
